/* hw/cpm_card.sv */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - upper data byte optional; 8-bit hosts work
// - host grounds A10..A03 in IDE mode
// - host ties write enable high in IDE
// - cable select ignored in PC Card modes
// - host drives cable select in PC modes
// - host without DMA holds acknowledge high
// - acknowledge ignored while no DMA active
// - IDE PIO: read, write strobes and ready
// - UDMA write: HSTROBE, STOP in; DDMARDY out
// - UDMA read: HDMARDY, STOP in; DSTROBE out
// - IDE mode supported beside PC modes
// - IDE decodes only three low address bits
module cpm_card
    import cpm_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  rst_in,
    // connector
    cpm_if.card                        bus,
    // mode and protocol state from the card core
    input  wire cpm_mode_type          mode_in,
    input  wire logic                  bus16_in,
    input  wire logic                  udma_wr_in,
    input  wire logic                  udma_rd_in,
    input  wire logic                  dma_active_in,
    // status sources, active high
    input  wire logic                  wp_in,
    input  wire logic                  ready_in,
    input  wire logic                  iois16_in,
    input  wire logic                  ireq_in,
    input  wire logic                  inpack_in,
    input  wire logic                  iocs16_in,
    input  wire logic                  intrq_in,
    input  wire logic                  dmarq_in,
    input  wire logic                  wait_in,
    input  wire logic                  iordy_in,
    input  wire logic                  ddmardy_in,
    input  wire logic                  dstrobe_in,
    input  wire logic                  pdiag_in,
    input  wire logic                  dasp_in,
    input  wire logic [CPM_DATA_W-1:0] rd_data_in,
    // decoded host requests
    output logic [CPM_ADDR_W-1:0]      addr_out,
    output logic [CPM_TREG_W-1:0]      task_reg_out,
    output logic                       card_sel_out,
    output logic                       rd_strobe_out,
    output logic                       wr_strobe_out,
    output logic [CPM_DATA_W-1:0]      wr_data_out,
    output logic                       hstrobe_out,
    output logic                       hdmardy_out,
    output logic                       stop_out,
    output logic                       dmack_out,
    output logic                       csel_out,
    output logic                       pdiag_seen_out,
    output logic                       dasp_seen_out
);

    // ****************************************************************
    // phase state
    // ****************************************************************
    cpm_phase_type phase_reg;
    cpm_phase_type phase_next;

    always_comb begin
        phase_next = cpm_phase(mode_in, udma_wr_in, udma_rd_in);
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_reg <= CPM_PH_PIO;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // ****************************************************************
    // inbound decode
    // ****************************************************************
    logic [CPM_ADDR_W-1:0] addr_reg,  addr_next;
    logic [CPM_TREG_W-1:0] treg_reg,  treg_next;
    logic                  sel_reg,   sel_next;
    logic                  rd_reg,    rd_next;
    logic                  wr_reg,    wr_next;
    logic [CPM_DATA_W-1:0] wdat_reg,  wdat_next;
    logic [2:0]            ud_reg,    ud_next;   // hstrobe, hdmardy, stop
    logic                  dmack_reg, dmack_next;
    logic                  csel_reg,  csel_next;
    logic [1:0]            hsk_reg,   hsk_next;  // pdiag, dasp seen low

    always_comb begin
        addr_next  = bus.h_addr;
        treg_next  = {CPM_TREG_W{1'b0}};
        sel_next   = !bus.h_ce1_n || !bus.h_ce2_n;
        rd_next    = 1'b0;
        wr_next    = 1'b0;
        wdat_next  = wdat_reg;
        ud_next    = 3'h0;
        dmack_next = 1'b0;
        csel_next  = 1'b0;
        hsk_next   = 2'h0;
        case (mode_in)
            CPM_MODE_MEM: begin
                rd_next = sel_next && !bus.h_oe_n;
                wr_next = sel_next && !bus.h_we_n;
            end
            CPM_MODE_IO: begin
                rd_next = sel_next && !bus.h_iord_n;
                wr_next = sel_next && !bus.h_iowr_n;
            end
            CPM_MODE_IDE: begin
                // upper address lines are grounded by the host anyway
                addr_next = {CPM_ADDR_HI0, bus.h_addr[2:0]};
                treg_next = bus.h_addr[2:0];
                csel_next = !bus.h_csel_n;
                hsk_next  = {!bus.pin46_w, !bus.pin45_w};
                // write enable is tied high in this mode, never looked at
                case (phase_reg)
                    CPM_PH_UDWR: begin
                        ud_next[2] = bus.h_iord_n;
                        ud_next[0] = bus.h_iowr_n;
                    end
                    CPM_PH_UDRD: begin
                        ud_next[1] = !bus.h_iord_n;
                        ud_next[0] = bus.h_iowr_n;
                    end
                    default: begin
                        rd_next = sel_next && !bus.h_iord_n;
                        wr_next = sel_next && !bus.h_iowr_n;
                    end
                endcase
            end
            default: begin
                sel_next = 1'b0;
            end
        endcase
        // a floating acknowledge on an old host must not leak through
        if (dma_active_in && mode_in == CPM_MODE_IDE) begin
            dmack_next = !bus.h_reg_n;
        end
        if (wr_next || ud_next[2]) begin
            // upper byte may be unconnected on an 8-bit host
            wdat_next = bus16_in ? bus.data_w
                                 : {CPM_BYTE0, bus.data_w[7:0]};
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_reg  <= CPM_ADDR0;
            treg_reg  <= {CPM_TREG_W{1'b0}};
            sel_reg   <= 1'b0;
            rd_reg    <= 1'b0;
            wr_reg    <= 1'b0;
            wdat_reg  <= CPM_WORD0;
            ud_reg    <= 3'h0;
            dmack_reg <= 1'b0;
            csel_reg  <= 1'b0;
            hsk_reg   <= 2'h0;
        end else begin
            addr_reg  <= addr_next;
            treg_reg  <= treg_next;
            sel_reg   <= sel_next;
            rd_reg    <= rd_next;
            wr_reg    <= wr_next;
            wdat_reg  <= wdat_next;
            ud_reg    <= ud_next;
            dmack_reg <= dmack_next;
            csel_reg  <= csel_next;
            hsk_reg   <= hsk_next;
        end
    end

    assign addr_out       = addr_reg;
    assign task_reg_out   = treg_reg;
    assign card_sel_out   = sel_reg;
    assign rd_strobe_out  = rd_reg;
    assign wr_strobe_out  = wr_reg;
    assign wr_data_out    = wdat_reg;
    assign hstrobe_out    = ud_reg[2];
    assign hdmardy_out    = ud_reg[1];
    assign stop_out       = ud_reg[0];
    assign dmack_out      = dmack_reg;
    assign csel_out       = csel_reg;
    assign pdiag_seen_out = hsk_reg[1];
    assign dasp_seen_out  = hsk_reg[0];

    // ****************************************************************
    // outbound pins
    // ****************************************************************
    logic [4:0]            pin_reg,  pin_next;  // 24,37,42,43,45,46 less one
    logic                  p46_reg,  p46_next;
    logic [1:0]            oe_reg,   oe_next;   // 46, 45; high releases
    logic [CPM_DATA_W-1:0] dout_reg, dout_next;
    logic [1:0]            doe_reg,  doe_next;

    always_comb begin
        pin_next  = {1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        p46_next  = 1'b1;
        oe_next   = 2'h0;
        dout_next = rd_data_in;
        doe_next  = 2'b11;
        case (mode_in)
            CPM_MODE_MEM: begin
                pin_next[0] = wp_in;
                pin_next[1] = ready_in;
                pin_next[2] = !wait_in;
                pin_next[3] = !inpack_in;
            end
            CPM_MODE_IO: begin
                pin_next[0] = !iois16_in;
                pin_next[1] = !ireq_in;
                pin_next[2] = !wait_in;
                pin_next[3] = !inpack_in;
            end
            CPM_MODE_IDE: begin
                pin_next[0] = !iocs16_in;
                pin_next[1] = intrq_in;
                pin_next[3] = dmarq_in;
                case (phase_next)
                    CPM_PH_UDWR: pin_next[2] = !ddmardy_in;
                    CPM_PH_UDRD: pin_next[2] = dstrobe_in;
                    default:     pin_next[2] = iordy_in;
                endcase
                // open drain: drive only the asserted low level
                pin_next[4] = 1'b0;
                p46_next    = 1'b0;
                oe_next     = {!pdiag_in, !dasp_in};
            end
            default: begin
                oe_next = 2'h3;
            end
        endcase
        if (rd_next || phase_next == CPM_PH_UDRD) begin
            doe_next = {!bus16_in, 1'b0};
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_reg  <= {1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            p46_reg  <= 1'b1;
            oe_reg   <= 2'h3;
            dout_reg <= CPM_WORD0;
            doe_reg  <= 2'b11;
        end else begin
            pin_reg  <= pin_next;
            p46_reg  <= p46_next;
            oe_reg   <= oe_next;
            dout_reg <= dout_next;
            doe_reg  <= doe_next;
        end
    end

    assign bus.c_pin24      = pin_reg[0];
    assign bus.c_pin37      = pin_reg[1];
    assign bus.c_pin42      = pin_reg[2];
    assign bus.c_pin43      = pin_reg[3];
    assign bus.c_pin45      = pin_reg[4];
    assign bus.c_pin45_oe_n = oe_reg[0];
    assign bus.c_pin46      = p46_reg;
    assign bus.c_pin46_oe_n = oe_reg[1];
    assign bus.c_data       = dout_reg;
    assign bus.c_data_oe_n  = doe_reg;

endmodule : cpm_card

`default_nettype wire

/* include/cpm_pkg.sv */
package cpm_pkg;

    // ****************************************************************
    // operating modes and transfer phases
    // ****************************************************************
    typedef enum logic [2:0] {
        CPM_MODE_MEM = 3'h1,
        CPM_MODE_IO  = 3'h2,
        CPM_MODE_IDE = 3'h4
    } cpm_mode_type;

    typedef enum logic [2:0] {
        CPM_PH_PIO  = 3'h1,
        CPM_PH_UDWR = 3'h2,
        CPM_PH_UDRD = 3'h4
    } cpm_phase_type;

    // ****************************************************************
    // widths and fixed levels
    // ****************************************************************
    localparam int          CPM_ADDR_W   = 11;
    localparam int          CPM_DATA_W   = 16;
    localparam int          CPM_TREG_W   = 3;
    localparam logic [7:0]  CPM_ADDR_HI0 = 8'h00;
    localparam logic [7:0]  CPM_BYTE0    = 8'h00;
    localparam logic [15:0] CPM_WORD0    = 16'h0000;
    localparam logic [10:0] CPM_ADDR0    = 11'h000;

    // phase from the two protocol flags; read wins a clash
    function automatic cpm_phase_type cpm_phase(
        input cpm_mode_type mode,
        input logic         ud_wr,
        input logic         ud_rd
    );
        cpm_phase = CPM_PH_PIO;
        if (mode == CPM_MODE_IDE && ud_rd) begin
            cpm_phase = CPM_PH_UDRD;
        end else if (mode == CPM_MODE_IDE && ud_wr) begin
            cpm_phase = CPM_PH_UDWR;
        end
    endfunction : cpm_phase

endpackage : cpm_pkg

/* include/cpm_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface cpm_if;
    import cpm_pkg::*;

    // host driven pins
    logic [CPM_ADDR_W-1:0] h_addr;
    logic                  h_ce1_n;
    logic                  h_ce2_n;
    logic                  h_oe_n;
    logic                  h_iord_n;
    logic                  h_iowr_n;
    logic                  h_we_n;
    logic                  h_reg_n;
    logic                  h_csel_n;
    logic [CPM_DATA_W-1:0] h_data;
    logic [1:0]            h_data_oe_n;
    // card driven pins
    logic [CPM_DATA_W-1:0] c_data;
    logic [1:0]            c_data_oe_n;
    logic                  c_pin24;
    logic                  c_pin37;
    logic                  c_pin42;
    logic                  c_pin43;
    logic                  c_pin45;
    logic                  c_pin45_oe_n;
    logic                  c_pin46;
    logic                  c_pin46_oe_n;
    // resolved wires
    logic                  pin45_w;
    logic                  pin46_w;
    logic [CPM_DATA_W-1:0] data_w;

    // pull-up when nobody drives the handshake pins
    assign pin45_w = c_pin45_oe_n ? 1'b1 : c_pin45;
    assign pin46_w = c_pin46_oe_n ? 1'b1 : c_pin46;
    assign data_w[7:0]  = !h_data_oe_n[0] ? h_data[7:0]  :
                          !c_data_oe_n[0] ? c_data[7:0]  : CPM_BYTE0;
    assign data_w[15:8] = !h_data_oe_n[1] ? h_data[15:8] :
                          !c_data_oe_n[1] ? c_data[15:8] : CPM_BYTE0;

    modport card (
        input  h_addr, h_ce1_n, h_ce2_n, h_oe_n, h_iord_n, h_iowr_n,
        input  h_we_n, h_reg_n, h_csel_n, data_w, pin45_w, pin46_w,
        output c_data, c_data_oe_n, c_pin24, c_pin37, c_pin42, c_pin43,
        output c_pin45, c_pin45_oe_n, c_pin46, c_pin46_oe_n
    );

    modport host (
        output h_addr, h_ce1_n, h_ce2_n, h_oe_n, h_iord_n, h_iowr_n,
        output h_we_n, h_reg_n, h_csel_n, h_data, h_data_oe_n,
        input  data_w, c_pin24, c_pin37, c_pin42, c_pin43,
        input  pin45_w, pin46_w
    );
endinterface : cpm_if

`default_nettype wire

/* hw/cpm_host.sv */
`timescale 1ns/10ps
`default_nettype none

module cpm_host
    import cpm_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  rst_in,
    // connector
    cpm_if.host                        bus,
    // configuration
    input  wire cpm_mode_type          mode_in,
    input  wire logic                  bus16_in,
    input  wire logic                  dma_used_in,
    input  wire logic                  a25_in,
    input  wire logic                  csel_gnd_in,
    input  wire logic                  ide_csel_in,
    // requests
    input  wire logic                  sel_in,
    input  wire logic                  word_in,
    input  wire logic                  attr_in,
    input  wire logic [CPM_ADDR_W-1:0] addr_in,
    input  wire logic                  rd_in,
    input  wire logic                  wr_in,
    input  wire logic [CPM_DATA_W-1:0] wr_data_in,
    // ultra dma controls
    input  wire logic                  udma_wr_in,
    input  wire logic                  udma_rd_in,
    input  wire logic                  hstrobe_in,
    input  wire logic                  hdmardy_in,
    input  wire logic                  stop_in,
    input  wire logic                  dmack_in,
    // card status as seen
    output logic [CPM_DATA_W-1:0]      rd_data_out,
    output logic [3:0]                 status_out,
    output logic                       pdiag_n_out,
    output logic                       dasp_n_out
);

    // ****************************************************************
    // pin drive
    // ****************************************************************
    cpm_phase_type         ph;
    logic [CPM_ADDR_W-1:0] addr_reg, addr_next;
    logic [7:0]            ctl_reg,  ctl_next;
    logic [CPM_DATA_W-1:0] dat_reg,  dat_next;
    logic [1:0]            doe_reg,  doe_next;
    logic [CPM_DATA_W-1:0] rdat_reg, rdat_next;
    logic [5:0]            st_reg,   st_next;
    logic                  ide;

    // ctl: ce1, ce2, oe, iord, iowr, we, reg, csel (all active low)
    always_comb begin
        ph        = cpm_phase(mode_in, udma_wr_in, udma_rd_in);
        ide       = (mode_in == CPM_MODE_IDE);
        addr_next = addr_in;
        ctl_next  = 8'hff;
        ctl_next[0] = !sel_in;
        ctl_next[1] = !(sel_in && word_in && bus16_in);
        dat_next  = wr_data_in;
        doe_next  = 2'b11;
        rdat_next = rdat_reg;
        if (ide) begin
            addr_next   = {CPM_ADDR_HI0, addr_in[2:0]};
            ctl_next[2] = 1'b0;
            ctl_next[5] = 1'b1;
            ctl_next[7] = !ide_csel_in;
            ctl_next[6] = dma_used_in ? !dmack_in : 1'b1;
            case (ph)
                CPM_PH_UDWR: begin
                    ctl_next[3] = hstrobe_in;
                    ctl_next[4] = stop_in;
                end
                CPM_PH_UDRD: begin
                    ctl_next[3] = !hdmardy_in;
                    ctl_next[4] = stop_in;
                end
                default: begin
                    ctl_next[3] = !rd_in;
                    ctl_next[4] = !wr_in;
                end
            endcase
        end else begin
            ctl_next[6] = !attr_in;
            // the card has no pull on this pin in these modes
            ctl_next[7] = csel_gnd_in ? 1'b0 : a25_in;
            if (mode_in == CPM_MODE_MEM) begin
                ctl_next[2] = !rd_in;
                ctl_next[5] = !wr_in;
            end else begin
                ctl_next[3] = !rd_in;
                ctl_next[4] = !wr_in;
            end
        end
        if (wr_in || ph == CPM_PH_UDWR) begin
            doe_next = {!bus16_in, 1'b0};
        end
        if (rd_in) begin
            rdat_next = bus16_in ? bus.data_w
                                 : {CPM_BYTE0, bus.data_w[7:0]};
        end
        st_next = {bus.pin46_w, bus.pin45_w, bus.c_pin43, bus.c_pin42,
                   bus.c_pin37, bus.c_pin24};
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_reg <= CPM_ADDR0;
            ctl_reg  <= 8'hff;
            dat_reg  <= CPM_WORD0;
            doe_reg  <= 2'b11;
            rdat_reg <= CPM_WORD0;
            st_reg   <= 6'h3f;
        end else begin
            addr_reg <= addr_next;
            ctl_reg  <= ctl_next;
            dat_reg  <= dat_next;
            doe_reg  <= doe_next;
            rdat_reg <= rdat_next;
            st_reg   <= st_next;
        end
    end

    assign bus.h_addr      = addr_reg;
    assign bus.h_ce1_n     = ctl_reg[0];
    assign bus.h_ce2_n     = ctl_reg[1];
    assign bus.h_oe_n      = ctl_reg[2];
    assign bus.h_iord_n    = ctl_reg[3];
    assign bus.h_iowr_n    = ctl_reg[4];
    assign bus.h_we_n      = ctl_reg[5];
    assign bus.h_reg_n     = ctl_reg[6];
    assign bus.h_csel_n    = ctl_reg[7];
    assign bus.h_data      = dat_reg;
    assign bus.h_data_oe_n = doe_reg;
    assign rd_data_out     = rdat_reg;
    assign status_out      = st_reg[3:0];
    assign dasp_n_out      = st_reg[4];
    assign pdiag_n_out     = st_reg[5];

endmodule : cpm_host

`default_nettype wire

/* test/cpm_asserts.sv */
`timescale 1ns/10ps
`default_nettype none

module cpm_asserts
    import cpm_pkg::*;
(
    // clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    // shared user controls
    input  wire cpm_mode_type mode_in,
    input  wire logic         udma_wr_in,
    input  wire logic         udma_rd_in,
    input  wire logic         hstrobe_in,
    input  wire logic         stop_in,
    input  wire logic         ddmardy_in,
    input  wire logic         dstrobe_in,
    // connector
    input  wire logic [10:0]  h_addr,
    input  wire logic         h_we_n,
    input  wire logic         h_iord_n,
    input  wire logic         h_iowr_n,
    input  wire logic [1:0]   h_data_oe_n,
    input  wire logic [1:0]   c_data_oe_n,
    input  wire logic         c_pin42,
    input  wire logic         pin45_w,
    input  wire logic         pin46_w
);
    logic [1:0] up_reg;
    logic [1:0] up_next;
    logic       ide;
    logic       pc;
    logic       uw;
    logic       ur;

    // outputs carry reset values for the first edges, so skip them
    always_comb begin
        up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            up_reg <= 2'h0;
        end else begin
            up_reg <= up_next;
        end
    end
    assign ide = (up_reg == 2'h3) && mode_in == CPM_MODE_IDE;
    assign pc  = (up_reg == 2'h3) && mode_in != CPM_MODE_IDE;
    assign uw  = ide && udma_wr_in && !udma_rd_in;
    assign ur  = ide && udma_rd_in;

    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    we_tied_a: assert property (ide && $past(ide) |-> h_we_n)
        else $error("write enable low in ide mode");
    addr_gnd_a: assert property (
        ide && $past(ide) |-> h_addr[10:3] == 8'h00)
        else $error("high address bits not grounded");
    pc_hand_a: assert property (
        pc && $past(pc) |-> pin45_w && pin46_w)
        else $error("handshake pins low in pc mode");
    no_clash_a: assert property (
        (h_data_oe_n | c_data_oe_n) == 2'b11)
        else $error("both ends drive one data byte");
    hstrobe_map_a: assert property (
        uw && $past(uw) && $past(uw, 2) |-> h_iord_n == $past(hstrobe_in))
        else $error("host strobe not on read pin");
    stop_map_a: assert property (
        (uw || ur) && $past(uw || ur) && $past(uw || ur, 2)
        |-> h_iowr_n == $past(stop_in))
        else $error("stop not on write pin");
    ddmardy_map_a: assert property (
        uw && $past(uw) && $past(uw, 2) |-> c_pin42 == !$past(ddmardy_in))
        else $error("device ready wrong on ready pin");
    dstrobe_map_a: assert property (
        ur && $past(ur) && $past(ur, 2) |-> c_pin42 == $past(dstrobe_in))
        else $error("device strobe wrong on ready pin");

    cover property (uw ##1 uw ##1 uw);
    cover property (ur ##1 ur ##1 ur);
    cover property (pc ##1 pc);
endmodule : cpm_asserts

`default_nettype wire

/* test/card_host_pin_function_map_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module card_host_pin_function_map_tb_top
    import cpm_pkg::*;
;
    logic         mclk_in, rst_in, bus16, uw, ur, act, a25, lv, ddr, dst;
    logic         sel, rd, wr, hs, hd, stp, ack, pd_n, ds_n;
    logic         sel_o, rs_o, ws_o, hs_o, hd_o, stp_o, ack_o, cs_o, pd_o;
    logic         ds_o;
    logic [2:0]   treg;
    logic [3:0]   stat;
    logic [10:0]  addr, addr_o;
    logic [15:0]  wdat, rdat, wd_o, rd_o;
    cpm_mode_type mode;
    int           failures, cmp_count;
    int           cyc = 0;

    cpm_if bus ();
    cpm_card i_cpm_card (
        .mclk_in(mclk_in), .rst_in(rst_in), .bus(bus), .mode_in(mode),
        .bus16_in(bus16), .udma_wr_in(uw), .udma_rd_in(ur),
        .dma_active_in(act), .wp_in(lv), .ready_in(lv), .iois16_in(lv),
        .ireq_in(lv), .inpack_in(lv), .iocs16_in(lv), .intrq_in(lv),
        .dmarq_in(lv), .wait_in(lv), .iordy_in(lv), .ddmardy_in(ddr),
        .dstrobe_in(dst), .pdiag_in(lv), .dasp_in(lv), .rd_data_in(rdat),
        .addr_out(addr_o), .task_reg_out(treg), .card_sel_out(sel_o),
        .rd_strobe_out(rs_o), .wr_strobe_out(ws_o), .wr_data_out(wd_o),
        .hstrobe_out(hs_o), .hdmardy_out(hd_o), .stop_out(stp_o),
        .dmack_out(ack_o), .csel_out(cs_o), .pdiag_seen_out(pd_o),
        .dasp_seen_out(ds_o));
    cpm_host i_cpm_host (
        .mclk_in(mclk_in), .rst_in(rst_in), .bus(bus), .mode_in(mode),
        .bus16_in(bus16), .dma_used_in(bus16), .a25_in(a25),
        .csel_gnd_in(1'b0), .ide_csel_in(1'b0), .sel_in(sel),
        .word_in(bus16), .attr_in(1'b0), .addr_in(addr), .rd_in(rd),
        .wr_in(wr), .wr_data_in(wdat), .udma_wr_in(uw), .udma_rd_in(ur),
        .hstrobe_in(hs), .hdmardy_in(hd), .stop_in(stp), .dmack_in(ack),
        .rd_data_out(rd_o), .status_out(stat), .pdiag_n_out(pd_n),
        .dasp_n_out(ds_n));
    cpm_asserts i_cpm_asserts (
        .mclk_in(mclk_in), .rst_in(rst_in), .mode_in(mode),
        .udma_wr_in(uw), .udma_rd_in(ur), .hstrobe_in(hs), .stop_in(stp),
        .ddmardy_in(ddr), .dstrobe_in(dst), .h_addr(bus.h_addr),
        .h_we_n(bus.h_we_n), .h_iord_n(bus.h_iord_n),
        .h_iowr_n(bus.h_iowr_n), .h_data_oe_n(bus.h_data_oe_n),
        .c_data_oe_n(bus.c_data_oe_n), .c_pin42(bus.c_pin42),
        .pin45_w(bus.pin45_w), .pin46_w(bus.pin46_w));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk_in);
    endtask : wait_n

    task automatic conclude;
        $display("compares=%0d mismatches=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // stray high address bits and an acknowledge while no dma runs
    task automatic ide_write_read(input logic w16);
        {bus16, sel, wr, ack} = {w16, 3'h7};
        addr = 11'h7fd;
        wdat = 16'habcd;
        wait_n(2);
        check({5'h0, addr_o}, 16'h0005);
        check({13'h0, treg}, 16'h0005);
        check({14'h0, sel_o, ws_o}, 16'h0003);
        check(wd_o, w16 ? 16'habcd : 16'h00cd);
        check({14'h0, bus.h_data_oe_n}, {14'h0, !w16, 1'b0});
        check({14'h0, ack_o, bus.h_reg_n}, {15'h0, !w16});
        {wr, rd} = 2'h1;
        rdat = 16'h5a3c;
        wait_n(4);
        check({15'h0, rs_o}, 16'h0001);
        check(rd_o, w16 ? 16'h5a3c : 16'h003c);
        {sel, rd, ack} = 3'h0;
        wait_n(2);
    endtask : ide_write_read

    task automatic status_map;
        cpm_mode_type m [3] = '{CPM_MODE_MEM, CPM_MODE_IO, CPM_MODE_IDE};
        logic [3:0]   e [6] = '{4'h3, 4'hc, 4'h0, 4'hf, 4'he, 4'h1};
        for (int i = 0; i < 6; i++) begin
            mode = m[i/2];
            {lv, a25} = {2{!i[0]}};
            wait_n(3);
            check({12'h0, stat}, {12'h0, e[i]});
            check({14'h0, pd_n, ds_n},
                  (i < 4) ? 16'h0003 : {14'h0, i[0], i[0]});
            check({14'h0, pd_o, ds_o}, {14'h0, {2{i > 3 && !i[0]}}});
            if (i < 4) begin
                check({14'h0, cs_o, bus.h_csel_n}, {15'h0, lv});
            end
        end
    endtask : status_map

    // strobe pins toggle low while the read and write strobes stay quiet
    task automatic udma_write;
        {act, ack, uw, sel, bus16} = 5'h1f;
        for (int i = 0; i < 4; i++) begin
            {hs, stp, ddr} = {i[0], i[1], i[0]};
            wait_n(3);
            check({12'h0, hs_o, stp_o, rs_o, ws_o},
                  {12'h0, i[0], i[1], 2'h0});
            check({15'h0, stat[2]}, {15'h0, !i[0]});
            check({15'h0, ack_o}, 16'h0001);
        end
        uw = 1'b0;
    endtask : udma_write

    task automatic udma_read;
        ur = 1'b1;
        for (int i = 0; i < 4; i++) begin
            {hd, stp, dst} = {i[0], i[1], i[0]};
            wait_n(3);
            check({12'h0, hd_o, stp_o, rs_o, ws_o},
                  {12'h0, i[0], i[1], 2'h0});
            check({15'h0, stat[2]}, {15'h0, i[0]});
        end
        {ur, act, ack, stp, sel} = 5'h00;
        wait_n(3);
    endtask : udma_read

    // ****************************************************************
    // run
    // ****************************************************************
    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = !mclk_in;
    end

    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        {bus16, uw, ur, act, a25, lv, ddr, dst} = 8'h00;
        {sel, rd, wr, hs, hd, stp, ack} = 7'h00;
        {addr, wdat, rdat} = '0;
        {failures, cmp_count} = '0;
        mode = CPM_MODE_IDE;
        rst_in = 1'b1;
        wait_n(16);
        rst_in = 1'b0;
        wait_n(2);
        ide_write_read(1'b1);
        ide_write_read(1'b0);
        status_map();
        udma_write();
        udma_read();
        conclude();
    end
endmodule : card_host_pin_function_map_tb_top

`default_nettype wire
